// ---- logic/dbg_pin_mux.sv ----
// Debug pin multiplexer with trace port and APB pin-setting registers.
// Assumes the debug port core and trace unit sit on pclk; pins arrive asynchronously.
`timescale 1ns/1ps

module dbg_pin_mux (
    input wire logic pclk, // System clock, 25 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic clk_en, // Freezes all state while low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic [dbg_pin_pkg::NUM_PINS-1:0] pin_in, // Pin levels from pads
    output logic [dbg_pin_pkg::NUM_PINS-1:0] pin_out, // Pin drive values
    output logic [dbg_pin_pkg::NUM_PINS-1:0] pin_oe, // Pin drive enables
    output logic [dbg_pin_pkg::NUM_PINS-1:0] pin_pullup, // Pull-up enables
    output logic [dbg_pin_pkg::NUM_PINS-1:0] pin_pulldown, // Pull-down enables
    input wire logic ext_reset_n_pin, // External reset pin, active low
    input wire logic stop_mode, // Device in stop mode
    input wire logic core_halted, // Processor in debug halt
    input wire logic swdio_out, // Serial data from debug core
    input wire logic swdio_oe, // Serial data drive request
    input wire logic tdo_out, // Test data out from debug core
    input wire logic tdo_oe, // Test data out drive request
    input wire logic swv_out, // Viewer trace bit
    input wire logic trace_clk_src, // Trace clock from trace unit
    input wire logic [3:0] trace_data, // Trace data from trace unit
    output logic dbg_tms, // Synced mode-select / serial data in
    output logic dbg_tdi, // Synced test data in
    output logic dbg_trst_n, // Synced test reset, active low
    output logic dbg_tck_rise, // One-cycle pulse on test clock rise
    output logic dbg_tck_fall, // One-cycle pulse on test clock fall
    output logic ext_reset_held, // External reset pin active
    output logic wdt_run // Watchdog run enable
);
    import dbg_pin_pkg::*;

    // ==========================================================
    // Registers
    // ==========================================================
    logic [9:0] func_sel_ff, in_en_ff, out_en_ff, pullup_ff, pulldown_ff, gp_out_ff;
    logic [2:0] ctrl_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;
    logic [10:0] sync1_ff, sync2_ff;
    logic tck_prev_ff;
    logic [9:0] pin_out_ff, pin_oe_ff, pin_pu_ff, pin_pd_ff;
    logic dbg_tms_ff, dbg_tdi_ff, dbg_trst_n_ff, dbg_tck_rise_ff, dbg_tck_fall_ff;
    logic ext_held_ff, wdt_run_ff;
    usage_t usage_ff;
    logic seen_ff;

    // ==========================================================
    // Bus decode
    // ==========================================================
    wire setup_ph = psel && !penable;
    wire wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
    wire hit_fs = paddr == OFS_FUNC_SEL;
    wire hit_ie = paddr == OFS_IN_EN;
    wire hit_oe = paddr == OFS_OUT_EN;
    wire hit_pu = paddr == OFS_PULLUP;
    wire hit_pd = paddr == OFS_PULLDOWN;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_stat = paddr == OFS_STATUS;
    wire hit_gpo = paddr == OFS_GP_OUT;
    wire hit_gpi = paddr == OFS_GP_IN;
    wire hit_any = hit_fs | hit_ie | hit_oe | hit_pu | hit_pd | hit_ctrl | hit_stat | hit_gpo | hit_gpi;

    // Synchronised pins and state seen by the logic
    wire [9:0] pin_sync = sync2_ff[9:0];
    wire ext_held_w = !sync2_ff[10];
    wire [9:0] pin_seen = pin_sync & in_en_ff;
    wire viewer_en = ctrl_ff[CTRL_VIEWER_EN];
    wire stby_drive = ctrl_ff[CTRL_STBY_DRIVE];
    wire trst_unused = ctrl_ff[CTRL_TRST_UNUSED];
    wire [31:0] status_w = {25'h0, stop_mode, ext_held_ff, core_halted, 1'b0, usage_ff};

    // Read data selection
    wire [31:0] rd_word = hit_fs ? {22'h0, func_sel_ff} :
                          hit_ie ? {22'h0, in_en_ff} :
                          hit_oe ? {22'h0, out_en_ff} :
                          hit_pu ? {22'h0, pullup_ff} :
                          hit_pd ? {22'h0, pulldown_ff} :
                          hit_ctrl ? {29'h0, ctrl_ff} :
                          hit_stat ? status_w :
                          hit_gpo ? {22'h0, gp_out_ff} :
                          hit_gpi ? {22'h0, pin_seen} : 32'h0;

    // ==========================================================
    // Usage configuration decode
    // ==========================================================
    function automatic usage_t decode_usage(input logic [9:0] fs, input logic swv, input logic no_trst);
        usage_t u;
        u = USE_CUSTOM;
        if (fs == ALL_PINS) begin
            u = USE_JTAG_TRACE;
        end else if (fs == DEBUG_FIVE) begin
            u = no_trst ? USE_JTAG_SW_NO_TRST : USE_JTAG_SW;
        end else if (fs == SW_VIEWER && swv) begin
            u = USE_SW_VIEWER;
        end else if (fs == SW_ONLY) begin
            u = USE_SW;
        end else if (fs == 10'h000) begin
            u = USE_DISABLED;
        end
        return u;
    endfunction : decode_usage

    wire usage_t nxt_usage = decode_usage(func_sel_ff, viewer_en, trst_unused);

    // ==========================================================
    // Pin drive selection
    // ==========================================================
    wire port_drive_ok = !stop_mode || stby_drive;
    wire [9:0] gp_oe = out_en_ff & {10{port_drive_ok}};
    wire dbg_ok = !ext_held_w;
    // Shared data-out pin: viewer trace or test data out
    wire dout_val = viewer_en ? swv_out : tdo_out;
    wire dout_req = viewer_en || tdo_oe;
    wire [9:0] dbg_val = {trace_data, trace_clk_src, 1'b0, 1'b0, dout_val, 1'b0, swdio_out};
    // Debug drivers ignore the stop-mode gate; only the serial data, data-out and five trace pins drive
    wire [9:0] dbg_oe = out_en_ff & {5'h1f, 1'b0, 1'b0, dout_req && dbg_ok, 1'b0, swdio_oe && dbg_ok};
    wire [9:0] nxt_pin_out = (func_sel_ff & dbg_val) | (~func_sel_ff & gp_out_ff);
    wire [9:0] nxt_pin_oe = (func_sel_ff & dbg_oe) | (~func_sel_ff & gp_oe);
    wire [9:0] nxt_pin_pu = pullup_ff;
    wire [9:0] nxt_pin_pd = pulldown_ff & PULLDOWN_MASK;

    // Debug inputs to the core, idle while the pin is not a debug pin or reset is held
    wire tck_live = pin_seen[PIN_TCLK] && func_sel_ff[PIN_TCLK];
    wire nxt_tms = pin_seen[PIN_MODE_DATA] && func_sel_ff[PIN_MODE_DATA] && dbg_ok;
    wire nxt_tdi = pin_seen[PIN_DATA_IN] && func_sel_ff[PIN_DATA_IN] && dbg_ok;
    wire nxt_trst_n = trst_unused || (pin_seen[PIN_TRST] && func_sel_ff[PIN_TRST] && dbg_ok);
    wire nxt_tck_rise = tck_live && !tck_prev_ff && dbg_ok;
    wire nxt_tck_fall = !tck_live && tck_prev_ff && dbg_ok;

    // ==========================================================
    // APB slave
    // ==========================================================
    // Answer registered in the setup cycle, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else if (clk_en) begin
            pready_ff <= setup_ph;
            pslverr_ff <= setup_ph && !hit_any;
            if (setup_ph) begin
                prdata_ff <= pwrite ? 32'h0 : rd_word;
            end
        end
    end

    // Pin setting registers with documented reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_sel_ff <= FUNC_SEL_RST;
            in_en_ff <= IN_EN_RST;
            out_en_ff <= OUT_EN_RST;
            pullup_ff <= PULLUP_RST;
            pulldown_ff <= PULLDOWN_RST;
        end else if (clk_en && wr_en) begin
            if (hit_fs) func_sel_ff <= pwdata[9:0];
            if (hit_ie) in_en_ff <= pwdata[9:0];
            if (hit_oe) out_en_ff <= pwdata[9:0];
            if (hit_pu) pullup_ff <= pwdata[9:0];
            if (hit_pd) pulldown_ff <= pwdata[9:0] & PULLDOWN_MASK;
        end
    end

    // Control and port data registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 3'h0;
            gp_out_ff <= 10'h000;
        end else if (clk_en && wr_en) begin
            if (hit_ctrl) ctrl_ff <= pwdata[2:0];
            if (hit_gpo) gp_out_ff <= pwdata[9:0];
        end
    end

    // ==========================================================
    // Pin synchronisers and test clock edge finder
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 11'h000;
            sync2_ff <= 11'h000;
            tck_prev_ff <= 1'b0;
        end else if (clk_en) begin
            sync1_ff <= {ext_reset_n_pin, pin_in};
            sync2_ff <= sync1_ff;
            tck_prev_ff <= tck_live;
        end
    end

    // ==========================================================
    // Output flops
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff <= 10'h000;
            pin_oe_ff <= 10'h000;
            pin_pu_ff <= PULLUP_RST;
            pin_pd_ff <= PULLDOWN_RST;
        end else if (clk_en) begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            pin_pu_ff <= nxt_pin_pu;
            pin_pd_ff <= nxt_pin_pd;
        end
    end

    // Debug core side flops, watchdog gate and status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_tms_ff <= 1'b0;
            dbg_tdi_ff <= 1'b0;
            dbg_trst_n_ff <= 1'b0;
            dbg_tck_rise_ff <= 1'b0;
            dbg_tck_fall_ff <= 1'b0;
            ext_held_ff <= 1'b1;
            wdt_run_ff <= 1'b1;
            usage_ff <= USE_JTAG_SW;
            seen_ff <= 1'b0;
        end else if (clk_en) begin
            dbg_tms_ff <= nxt_tms;
            dbg_tdi_ff <= nxt_tdi;
            dbg_trst_n_ff <= nxt_trst_n;
            dbg_tck_rise_ff <= nxt_tck_rise;
            dbg_tck_fall_ff <= nxt_tck_fall;
            ext_held_ff <= ext_held_w;
            wdt_run_ff <= !core_halted;
            usage_ff <= nxt_usage;
            seen_ff <= 1'b1;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign pin_pullup = pin_pu_ff;
    assign pin_pulldown = pin_pd_ff;
    assign dbg_tms = dbg_tms_ff;
    assign dbg_tdi = dbg_tdi_ff;
    assign dbg_trst_n = dbg_trst_n_ff;
    assign dbg_tck_rise = dbg_tck_rise_ff;
    assign dbg_tck_fall = dbg_tck_fall_ff;
    assign ext_reset_held = ext_held_ff;
    assign wdt_run = wdt_run_ff;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_reset_pin_setup: assert property (
        !seen_ff |-> func_sel_ff == FUNC_SEL_RST && out_en_ff == OUT_EN_RST && in_en_ff == IN_EN_RST)
        else $error("pin settings wrong after reset");
    chk_reset_pull_setup: assert property (
        !seen_ff |-> pullup_ff == PULLUP_RST && pulldown_ff == PULLDOWN_RST)
        else $error("pull settings wrong after reset");
    chk_viewer_drive: assert property (
        clk_en && func_sel_ff[PIN_DATA_OUT] && viewer_en |=> pin_out_ff[PIN_DATA_OUT] == $past(swv_out))
        else $error("viewer bit not on data-out pin");
    chk_trace_data: assert property (
        clk_en && func_sel_ff[PIN_TRACE_D0] |=> pin_out_ff[PIN_TRACE_D0] == $past(trace_data[0]))
        else $error("trace data not on trace pin");
    chk_debug_stop_drive: assert property (
        clk_en && stop_mode && !stby_drive && func_sel_ff[PIN_MODE_DATA] && out_en_ff[PIN_MODE_DATA]
        && swdio_oe && !ext_held_w |=> pin_oe_ff[PIN_MODE_DATA])
        else $error("serial data driver dropped in stop");
    chk_port_stop_gate: assert property (
        clk_en && stop_mode && !stby_drive && !func_sel_ff[PIN_TRACE_CLK] |=> !pin_oe_ff[PIN_TRACE_CLK])
        else $error("port driver left on in stop");
    chk_wdt_halt: assert property (
        clk_en && core_halted ##1 clk_en && core_halted |-> !wdt_run_ff ##1 !wdt_run_ff)
        else $error("watchdog running during halt");
    chk_ext_reset_quiet: assert property (
        clk_en && ext_held_w |=> !dbg_tck_rise_ff && !dbg_tck_fall_ff && !pin_oe_ff[PIN_MODE_DATA])
        else $error("debug traffic during external reset");
    chk_pulldown_only: assert property (
        (pin_pd_ff & ~PULLDOWN_MASK) == 10'h000)
        else $error("pull-down on a pin without one");
    chk_usage_sw: assert property (
        clk_en && func_sel_ff == SW_ONLY |=> usage_ff == USE_SW)
        else $error("serial-wire only usage not reported");
    chk_tms_share: assert property (
        clk_en && func_sel_ff[PIN_MODE_DATA] && in_en_ff[PIN_MODE_DATA] && !ext_held_w
        |=> dbg_tms_ff == $past(pin_sync[PIN_MODE_DATA]))
        else $error("mode/data pin not passed to debug core");

    cov_tck_edge: cover property (dbg_tck_rise_ff ##[1:20] dbg_tck_fall_ff);
    cov_viewer_on: cover property (usage_ff == USE_SW_VIEWER);
    cov_bus_error: cover property (pready_ff && pslverr_ff);

endmodule : dbg_pin_mux

// ---- logic/dbg_pin_pkg.sv ----
// Constants for the debug pin multiplexer and trace port block.
// Assumes a 32-bit APB register bus; offsets below are byte addresses.
package dbg_pin_pkg;

    // ==========================================================
    // Pin numbering inside the ten-bit pin vectors
    // ==========================================================
    localparam int unsigned NUM_PINS = 10;
    localparam int unsigned PIN_MODE_DATA = 0; // port_a_line_zero
    localparam int unsigned PIN_TCLK = 1; // port_a_line_one
    localparam int unsigned PIN_DATA_OUT = 2; // port_b_line_zero
    localparam int unsigned PIN_DATA_IN = 3; // port_b_line_one
    localparam int unsigned PIN_TRST = 4; // port_b_line_two
    localparam int unsigned PIN_TRACE_CLK = 5; // port_a_line_two
    localparam int unsigned PIN_TRACE_D0 = 6; // port_a_line_three .. six follow

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
    localparam logic [7:0] OFS_IN_EN = 8'h04;
    localparam logic [7:0] OFS_OUT_EN = 8'h08;
    localparam logic [7:0] OFS_PULLUP = 8'h0c;
    localparam logic [7:0] OFS_PULLDOWN = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_GP_OUT = 8'h1c;
    localparam logic [7:0] OFS_GP_IN = 8'h20;

    // ==========================================================
    // Reset values of the pin setting registers, pull-down mask and function-select patterns
    // ==========================================================
    localparam logic [9:0] FUNC_SEL_RST = 10'h01f;
    localparam logic [9:0] IN_EN_RST = 10'h01b;
    localparam logic [9:0] OUT_EN_RST = 10'h005;
    localparam logic [9:0] PULLUP_RST = 10'h019;
    localparam logic [9:0] PULLDOWN_RST = 10'h002;
    localparam logic [9:0] PULLDOWN_MASK = 10'h002;
    localparam logic [9:0] DEBUG_FIVE = 10'h01f;
    localparam logic [9:0] SW_ONLY = 10'h003;
    localparam logic [9:0] SW_VIEWER = 10'h007;
    localparam logic [9:0] ALL_PINS = 10'h3ff;

    // ==========================================================
    // Control and status field positions
    // ==========================================================
    localparam int unsigned CTRL_VIEWER_EN = 0;
    localparam int unsigned CTRL_STBY_DRIVE = 1;
    localparam int unsigned CTRL_TRST_UNUSED = 2;
    localparam int unsigned STAT_HALTED = 4;
    localparam int unsigned STAT_EXT_RESET = 5;
    localparam int unsigned STAT_STOP = 6;

    // Pin usage configuration reported in status bits 2:0
    typedef enum logic [2:0] {
        USE_DISABLED = 3'b000,
        USE_JTAG_SW = 3'b001,
        USE_JTAG_SW_NO_TRST = 3'b010,
        USE_JTAG_TRACE = 3'b011,
        USE_SW = 3'b100,
        USE_SW_VIEWER = 3'b101,
        USE_CUSTOM = 3'b111
    } usage_t;

endpackage : dbg_pin_pkg

// ---- tb/dbg_pin_mux_tb.sv ----
// Self-checking bench for the debug pin multiplexer: APB registers, pin routing, probe link.
// Assumes dbg_pin_mux and dbg_pin_pkg from logic/ and the probe model dbg_probe.
`timescale 1ns/1ps

module dbg_pin_mux_tb;
    import dbg_pin_pkg::*;

    // ==========================================================
    // Signals
    // ==========================================================
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic [9:0] pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown, drv, drv_en;
    logic [9:0] float_v = 10'h155;
    logic ext_reset_n_pin = 1'b1, stop_mode = 1'b0, core_halted = 1'b0, swdio_out = 1'b0;
    logic swdio_oe = 1'b0, tdo_out = 1'b0, tdo_oe = 1'b0, swv_out = 1'b0, trace_clk_src = 1'b0;
    logic rude = 1'b0, clk_en = 1'b1;
    logic [3:0] trace_data = 4'h0;
    logic dbg_tms, dbg_tdi, dbg_trst_n, dbg_tck_rise, dbg_tck_fall, ext_reset_held, wdt_run;
    int mismatches = 0, checked = 0, rises = 0, falls = 0;

    // Clock, wandering level for undriven pads, test clock edge count
    always #20 pclk = ~pclk;
    always @(posedge pclk) float_v <= ~float_v;
    always @(posedge pclk) if (dbg_tck_rise === 1'b1) rises <= rises + 1;
    always @(posedge pclk) if (dbg_tck_fall === 1'b1) falls <= falls + 1;

    // Pad level: own driver, then probe, then pulls
    for (genvar i = 0; i < 10; i++) begin : g_pad
        assign pin_in[i] = pin_oe[i] ? pin_out[i] : drv_en[i] ? drv[i] :
            pin_pullup[i] ? 1'b1 : pin_pulldown[i] ? 1'b0 : float_v[i];
    end

    dbg_pin_mux u_dbg_pin_mux (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_pulldown, .ext_reset_n_pin,
        .stop_mode, .core_halted, .swdio_out, .swdio_oe, .tdo_out, .tdo_oe, .swv_out, .trace_clk_src,
        .trace_data, .dbg_tms, .dbg_tdi, .dbg_trst_n, .dbg_tck_rise, .dbg_tck_fall, .ext_reset_held, .wdt_run);
    dbg_probe u_dbg_probe (.ext_reset_n(ext_reset_n_pin), .rude, .drv, .drv_en);

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            $display("MISMATCH at %0t: pready %h expected %h", $time, pready, 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk

    task automatic end_sim;
        $display("Counts: checked %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset;
        logic [7:0] ofs[7] = '{OFS_FUNC_SEL, OFS_IN_EN, OFS_OUT_EN, OFS_PULLUP, OFS_PULLDOWN, OFS_CTRL, OFS_STATUS};
        logic [9:0] exp[7] = '{FUNC_SEL_RST, IN_EN_RST, OUT_EN_RST, PULLUP_RST, PULLDOWN_RST, 10'h000, 10'h001};
        for (int i = 0; i < 7; i++) rchk(ofs[i], 32'(exp[i]));
        chk(32'({pin_pullup, pin_pulldown}), {12'h0, PULLUP_RST, PULLDOWN_RST});
        rchk(8'h24, 32'h0);
        chk(32'(err), 32'h1);
        wr(OFS_STATUS, 32'h7f);
        rchk(OFS_STATUS, 32'h1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_usage;
        logic [9:0] fs[7] = '{10'h000, DEBUG_FIVE, DEBUG_FIVE, ALL_PINS, SW_ONLY, SW_VIEWER, 10'h00f};
        logic [2:0] ct[7] = '{3'h0, 3'h0, 3'h4, 3'h0, 3'h0, 3'h1, 3'h0};
        usage_t ex[7] = '{USE_DISABLED, USE_JTAG_SW, USE_JTAG_SW_NO_TRST, USE_JTAG_TRACE, USE_SW,
            USE_SW_VIEWER, USE_CUSTOM};
        for (int i = 0; i < 7; i++) begin
            wr(OFS_FUNC_SEL, 32'(fs[i]));
            wr(OFS_CTRL, 32'(ct[i]));
            rchk(OFS_STATUS, 32'(ex[i]));
        end
        $display("test usage done");
    endtask : t_usage

    task automatic t_viewer;
        wr(OFS_FUNC_SEL, 32'(DEBUG_FIVE));
        wr(OFS_CTRL, 32'h1);
        swv_out <= 1'b1;
        tick(2);
        chk(32'({pin_oe[2], pin_out[2]}), 32'h3);
        wr(OFS_CTRL, 32'h0);
        tdo_oe <= 1'b1;
        tick(2);
        chk(32'({pin_oe[2], pin_out[2]}), 32'h2);
        tdo_oe <= 1'b0;
        tick(2);
        chk(32'(pin_oe[2]), 32'h0);
        $display("test viewer done");
    endtask : t_viewer

    task automatic t_trace_stop;
        wr(OFS_FUNC_SEL, 32'(ALL_PINS));
        wr(OFS_OUT_EN, 32'(ALL_PINS));
        trace_data <= 4'ha;
        trace_clk_src <= 1'b1;
        tick(2);
        chk(32'({pin_oe[9:5], pin_out[9:5]}), 32'h3f5);
        wr(OFS_FUNC_SEL, 32'(DEBUG_FIVE));
        wr(OFS_GP_OUT, 32'h140);
        swdio_oe <= 1'b1;
        swdio_out <= 1'b1;
        stop_mode <= 1'b1;
        tick(2);
        chk(32'({pin_oe[0], pin_out[0], pin_oe[9:5]}), 32'h60);
        wr(OFS_CTRL, 32'h2);
        tick(2);
        chk(32'({pin_oe[9:5], pin_out[9:5]}), 32'h3ea);
        stop_mode <= 1'b0;
        swdio_oe <= 1'b0;
        wr(OFS_CTRL, 32'h0);
        wr(OFS_OUT_EN, 32'(OUT_EN_RST));
        $display("test trace and stop done");
    endtask : t_trace_stop

    task automatic t_halt;
        // Halt with the clock enable low: all state frozen
        clk_en <= 1'b0;
        core_halted <= 1'b1;
        tick(3);
        chk(32'(wdt_run), 32'h1);
        clk_en <= 1'b1;
        tick(2);
        chk(32'(wdt_run), 32'h0);
        core_halted <= 1'b0;
        tick(2);
        chk(32'(wdt_run), 32'h1);
        $display("test halt done");
    endtask : t_halt

    task automatic t_link;
        int base, fbase;
        base = rises;
        fbase = falls;
        u_dbg_probe.frame(6);
        tick(6);
        chk(32'(rises - base), 32'd6);
        chk(32'(falls - fbase), 32'd6);
        chk(32'({dbg_tms, dbg_tdi, dbg_trst_n}), 32'h7);
        ext_reset_n_pin <= 1'b0;
        tick(4);
        rchk(OFS_STATUS, 32'h21);
        rude <= 1'b1;
        u_dbg_probe.frame(4);
        tick(6);
        chk(32'(rises - base), 32'd6);
        chk(32'(falls - fbase), 32'd6);
        chk(32'({ext_reset_held, dbg_tms, dbg_tdi, dbg_trst_n}), 32'h8);
        rude <= 1'b0;
        ext_reset_n_pin <= 1'b1;
        tick(4);
        wr(OFS_FUNC_SEL, 32'h01d);
        $display("test link done");
    endtask : t_link

    // Reset request after breakpoints, issued in the normal clock mode only
    task automatic t_rereset;
        wr(OFS_PULLUP, 32'h0);
        presetn <= 1'b0;
        tick(3);
        presetn <= 1'b1;
        tick(1);
        chk(32'({pin_pullup, ext_reset_held, wdt_run}), 32'({PULLUP_RST, 2'b11}));
        rchk(OFS_FUNC_SEL, 32'(FUNC_SEL_RST));
        rchk(OFS_PULLUP, 32'(PULLUP_RST));
        $display("test reset request done");
    endtask : t_rereset

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_usage();
        t_viewer();
        t_trace_stop();
        t_halt();
        t_link();
        t_rereset();
        end_sim();
    end

    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule : dbg_pin_mux_tb

// ---- tb/dbg_probe.sv ----
// Behavioural debug probe driving the mode/data, test clock, data-in and test-reset pads.
// Assumes the bench resolves pad levels and starts each frame by calling frame().
`timescale 1ns/1ps

module dbg_probe (
    input wire logic ext_reset_n, // Device reset pin level
    input wire logic rude, // Talk through a held reset on purpose
    output logic [9:0] drv, // Levels offered to the pads
    output logic [9:0] drv_en // Pads the probe drives
);
    // ==========================================================
    // Idle: test clock stands low, test-reset held high
    // ==========================================================
    initial begin
        drv = 10'h010;
        drv_en = 10'h01b;
    end

    // One frame of n test clock cycles of 320 ns
    task automatic frame(input int n);
        #13;
        while (ext_reset_n !== 1'b1 && rude !== 1'b1) #40;
        for (int i = 0; i < n; i++) begin
            drv[0] = i[0];
            drv[3] = ~i[0];
            #160 drv[1] = 1'b1;
            #160 drv[1] = 1'b0;
        end
        drv[0] = 1'b1;
        drv[3] = 1'b1;
    endtask : frame
endmodule : dbg_probe
